// ### hdl/cpc_pkg.sv
// Operation
// R1 - message is 32-bit port number, 16-bit event, 16-bit value, little-endian
// R2 - with multiport, device sends on control receive queue, driver on transmit
// R3 - driver sends event 0 once ready; value 1 success, 0 failure; port ignored
// R4 - device creates a port with event 1; value carries nothing
// R5 - device removes a port with event 2; value carries nothing
// R6 - driver answers a creation with event 3; value 1 success, 0 failure
// R7 - device nominates console ports with event 4; several may be consoles
// R8 - resize is event 5, then 16-bit columns and 16-bit rows
// R9 - either side sends event 6 for open state; 0 closed, 1 open
// R10 - name is event 7 followed by UTF-8 bytes, no terminating zero
// R11 - never create an existing port or one at or above the limit
// R12 - never remove a port that was not created
// R13 - driver must send the readiness message when multiport is negotiated
// R14 - driver treats nominated port as console and answers open with value 1
// R15 - in legacy mode fields use guest native order instead of little-endian
// R16 - legacy driver ignores used lengths on transmit and control transmit queues
// R17 - legacy driver without any-layout puts each control buffer in one descriptor
// R18 - with multiport the device exposes a 32-bit maximum port count
// R19 - creation message also announces hot-plugged ports
// R20 - port 0 queues always exist; control queues only with multiport
// R21 - driver messages with unknown event codes are dropped, state untouched
package cpc_pkg;
  localparam logic [31:0] PORT_COUNT_LIMIT = 32'h0000_0008;
  localparam int          NPORT            = int'(PORT_COUNT_LIMIT);
  localparam int          PW               = $clog2(NPORT);

  localparam logic [15:0] EV_DRV_READY     = 16'h0000;
  localparam logic [15:0] EV_PORT_ADD      = 16'h0001;
  localparam logic [15:0] EV_PORT_REMOVE   = 16'h0002;
  localparam logic [15:0] EV_PORT_READY    = 16'h0003;
  localparam logic [15:0] EV_CONSOLE       = 16'h0004;
  localparam logic [15:0] EV_RESIZE        = 16'h0005;
  localparam logic [15:0] EV_PORT_OPEN     = 16'h0006;
  localparam logic [15:0] EV_PORT_NAME     = 16'h0007;

  // byte indices inside a frame: 0-3 port, 4-5 event, 6-7 value, 8-9 cols, 10-11 rows
  localparam logic [3:0]  IDX_EVENT        = 4'h4;
  localparam logic [3:0]  IDX_VALUE        = 4'h6;
  localparam logic [3:0]  IDX_HDR_LAST     = 4'h7;
  localparam logic [3:0]  IDX_COLS         = 4'h8;
  localparam logic [3:0]  IDX_ROWS         = 4'hA;
  localparam logic [3:0]  IDX_EXT_LAST     = 4'hB;

  localparam logic [NPORT-1:0] EXISTS_RST  = NPORT'(1);

  typedef enum logic [1:0] {CPC_IDLE, CPC_HDR, CPC_EXT, CPC_NAME} cpc_tx_e;
endpackage

// ### hdl/cpc_console_ctrl.sv
`timescale 1ns/1ps
module cpc_console_ctrl (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      multiport_en,
  input  wire logic                      legacy_be,
  input  wire logic                      cmd_valid,
  output logic                           cmd_ready,
  input  wire logic [15:0]               cmd_event,
  input  wire logic [31:0]               cmd_port,
  input  wire logic [15:0]               cmd_value,
  input  wire logic [15:0]               cmd_cols,
  input  wire logic [15:0]               cmd_rows,
  output logic                           cmd_reject,
  input  wire logic                      name_valid,
  output logic                           name_ready,
  input  wire logic [7:0]                name_data,
  input  wire logic                      name_last,
  output logic                           rxq_valid,
  input  wire logic                      rxq_ready,
  output logic [7:0]                     rxq_data,
  output logic                           rxq_last,
  input  wire logic                      txq_valid,
  output logic                           txq_ready,
  input  wire logic [7:0]                txq_data,
  input  wire logic                      txq_last,
  output logic [31:0]                    port_count_limit,
  output logic                           drv_ready,
  output logic [cpc_pkg::NPORT-1:0]      port_exists,
  output logic [cpc_pkg::NPORT-1:0]      port_ok,
  output logic [cpc_pkg::NPORT-1:0]      guest_open,
  output logic [cpc_pkg::NPORT-1:0]      console_port
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_q;
  logic       rst_i_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rst_q <= 2'h0;
    else        rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_i_n = rst_q[1];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] frame_byte(input logic [3:0] k, input logic [31:0] id,
      input logic [15:0] ev, input logic [15:0] val, input logic [15:0] cols,
      input logic [15:0] rows, input logic be);
    logic [1:0]  j;
    logic        h;
    logic [15:0] f;
    j = be ? ~k[1:0] : k[1:0];
    h = be ? ~k[0] : k[0];
    f = k < cpc_pkg::IDX_VALUE ? ev : k < cpc_pkg::IDX_COLS ? val :
        k < cpc_pkg::IDX_ROWS  ? cols : rows;
    if (k < cpc_pkg::IDX_EVENT) frame_byte = id[{j, 3'h0} +: 8];
    else                        frame_byte = f[{h, 3'h0} +: 8];
  endfunction

  function automatic logic [15:0] pick16(input logic [7:0] lo, input logic [7:0] hi,
      input logic be);
    pick16 = be ? {lo, hi} : {hi, lo};
  endfunction

  // ---------------------------------------------------------------
  // device to driver message sender
  // ---------------------------------------------------------------
  cpc_pkg::cpc_tx_e state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [31:0] id_q, id_d;
  logic [15:0] ev_q, ev_d, val_q, val_d, cols_q, cols_d, rows_q, rows_d;
  logic        be_q, be_d;
  logic        rxq_valid_q, rxq_valid_d, rxq_last_q, rxq_last_d;
  logic [7:0]  rxq_data_q, rxq_data_d;
  logic        cmd_ready_q, cmd_ready_d, name_ready_q, name_ready_d;
  logic        cmd_reject_q, cmd_reject_d;
  logic        slot_free, cmd_take, port_in, port_ex, cmd_ok;
  logic [cpc_pkg::PW-1:0] cmd_idx;
  logic [cpc_pkg::NPORT-1:0] port_exists_q;

  assign slot_free = !rxq_valid_q || rxq_ready;
  assign cmd_take  = cmd_valid && cmd_ready_q;
  assign cmd_idx   = cmd_port[cpc_pkg::PW-1:0];
  assign port_in   = cmd_port < cpc_pkg::PORT_COUNT_LIMIT;
  assign port_ex   = port_in && port_exists_q[cmd_idx];

  always_comb begin
    unique case (cmd_event)
      cpc_pkg::EV_PORT_ADD:    cmd_ok = port_in && !port_ex; // R11 R19
      cpc_pkg::EV_PORT_REMOVE: cmd_ok = port_ex && cmd_idx != '0; // R12 R20
      cpc_pkg::EV_CONSOLE,
      cpc_pkg::EV_RESIZE,
      cpc_pkg::EV_PORT_OPEN,
      cpc_pkg::EV_PORT_NAME:   cmd_ok = port_ex;
      default:                 cmd_ok = 1'b0;
    endcase
    cmd_ok = cmd_ok && multiport_en; // R2 R20
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    id_d = id_q;
    ev_d = ev_q;
    val_d = val_q;
    cols_d = cols_q;
    rows_d = rows_q;
    be_d = be_q;
    rxq_valid_d = rxq_valid_q && !rxq_ready;
    rxq_data_d = rxq_data_q;
    rxq_last_d = rxq_last_q;
    cmd_reject_d = 1'b0;
    unique case (state_q)
      cpc_pkg::CPC_IDLE: begin
        if (cmd_take && cmd_ok) begin
          id_d = cmd_port;
          ev_d = cmd_event;
          val_d = cmd_value;
          cols_d = cmd_cols;
          rows_d = cmd_rows;
          be_d = legacy_be; // R15
          cnt_d = 4'h0;
          state_d = cpc_pkg::CPC_HDR;
        end else if (cmd_take) begin
          cmd_reject_d = 1'b1;
        end
      end
      cpc_pkg::CPC_HDR: begin
        if (slot_free) begin
          rxq_valid_d = 1'b1;
          rxq_data_d = frame_byte(cnt_q, id_q, ev_q, val_q, cols_q, rows_q, be_q); // R1 R15
          rxq_last_d = cnt_q == cpc_pkg::IDX_HDR_LAST && ev_q != cpc_pkg::EV_RESIZE &&
                       ev_q != cpc_pkg::EV_PORT_NAME; // R8 R10
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == cpc_pkg::IDX_HDR_LAST) begin
            if (ev_q == cpc_pkg::EV_RESIZE)         state_d = cpc_pkg::CPC_EXT; // R8
            else if (ev_q == cpc_pkg::EV_PORT_NAME) state_d = cpc_pkg::CPC_NAME; // R10
            else                                    state_d = cpc_pkg::CPC_IDLE;
          end
        end
      end
      cpc_pkg::CPC_EXT: begin
        if (slot_free) begin
          rxq_valid_d = 1'b1;
          rxq_data_d = frame_byte(cnt_q, id_q, ev_q, val_q, cols_q, rows_q, be_q); // R8
          rxq_last_d = cnt_q == cpc_pkg::IDX_EXT_LAST;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == cpc_pkg::IDX_EXT_LAST) state_d = cpc_pkg::CPC_IDLE;
        end
      end
      cpc_pkg::CPC_NAME: begin
        // the name passes through untouched; its last byte ends the message
        if (name_valid && name_ready_q) begin
          rxq_valid_d = 1'b1;
          rxq_data_d = name_data; // R10
          rxq_last_d = name_last;
          if (name_last) state_d = cpc_pkg::CPC_IDLE;
        end
      end
    endcase
    cmd_ready_d = state_d == cpc_pkg::CPC_IDLE;
    // registered ready only opens on an empty slot, so a name byte costs two cycles
    name_ready_d = state_d == cpc_pkg::CPC_NAME && !rxq_valid_d;
  end

  always_ff @(posedge clk_sys or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state_q <= cpc_pkg::CPC_IDLE;
      cnt_q <= 4'h0;
      id_q <= 32'h0;
      ev_q <= 16'h0;
      val_q <= 16'h0;
      cols_q <= 16'h0;
      rows_q <= 16'h0;
      be_q <= 1'b0;
      rxq_valid_q <= 1'b0;
      rxq_data_q <= 8'h0;
      rxq_last_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      name_ready_q <= 1'b0;
      cmd_reject_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      id_q <= id_d;
      ev_q <= ev_d;
      val_q <= val_d;
      cols_q <= cols_d;
      rows_q <= rows_d;
      be_q <= be_d;
      rxq_valid_q <= rxq_valid_d;
      rxq_data_q <= rxq_data_d;
      rxq_last_q <= rxq_last_d;
      cmd_ready_q <= cmd_ready_d;
      name_ready_q <= name_ready_d;
      cmd_reject_q <= cmd_reject_d;
    end
  end

  // ---------------------------------------------------------------
  // driver to device parser and port state
  // ---------------------------------------------------------------
  logic [7:0]  rxb_q [0:6];
  logic [7:0]  rxb_d [0:6];
  logic [3:0]  rcnt_q, rcnt_d;
  logic        txq_ready_q, drv_ready_q, drv_ready_d;
  logic [cpc_pkg::NPORT-1:0] port_exists_d, port_ok_q, port_ok_d;
  logic [cpc_pkg::NPORT-1:0] guest_open_q, guest_open_d, console_q, console_d;
  logic        beat, apply;
  logic [31:0] r_id;
  logic [15:0] r_ev, r_val;
  logic        r_in;
  logic [cpc_pkg::PW-1:0] r_idx;

  assign beat  = txq_valid && txq_ready_q;
  assign apply = beat && rcnt_q == cpc_pkg::IDX_HDR_LAST && multiport_en; // R2
  assign r_id  = legacy_be ? {rxb_q[0], rxb_q[1], rxb_q[2], rxb_q[3]} :
                             {rxb_q[3], rxb_q[2], rxb_q[1], rxb_q[0]}; // R1 R15
  assign r_ev  = pick16(rxb_q[4], rxb_q[5], legacy_be);
  assign r_val = pick16(rxb_q[6], txq_data, legacy_be);
  assign r_in  = r_id < cpc_pkg::PORT_COUNT_LIMIT;
  assign r_idx = r_id[cpc_pkg::PW-1:0];

  always_comb begin
    rxb_d = rxb_q;
    rcnt_d = rcnt_q;
    drv_ready_d = drv_ready_q;
    port_exists_d = port_exists_q;
    port_ok_d = port_ok_q;
    guest_open_d = guest_open_q;
    console_d = console_q;
    if (beat) begin
      // bytes past the eighth are dropped; a short frame never applies
      if (rcnt_q < cpc_pkg::IDX_HDR_LAST) rxb_d[rcnt_q[2:0]] = txq_data;
      if (txq_last)                           rcnt_d = 4'h0;
      else if (rcnt_q <= cpc_pkg::IDX_HDR_LAST) rcnt_d = rcnt_q + 4'h1;
    end
    if (apply) begin
      unique case (r_ev)
        cpc_pkg::EV_DRV_READY: drv_ready_d = r_val == 16'h0001;
        cpc_pkg::EV_PORT_READY:
          if (r_in && port_exists_q[r_idx]) port_ok_d[r_idx] = r_val == 16'h0001;
        cpc_pkg::EV_PORT_OPEN: // R9
          if (r_in && port_exists_q[r_idx] && r_val[15:1] == 15'h0)
            guest_open_d[r_idx] = r_val[0];
        default: ; // R21
      endcase
    end
    if (cmd_take && cmd_ok) begin
      unique case (cmd_event)
        cpc_pkg::EV_PORT_ADD: begin
          port_exists_d[cmd_idx] = 1'b1; // R4 R19
          port_ok_d[cmd_idx] = 1'b0;
          guest_open_d[cmd_idx] = 1'b0;
          console_d[cmd_idx] = 1'b0;
        end
        cpc_pkg::EV_PORT_REMOVE: begin
          port_exists_d[cmd_idx] = 1'b0; // R5
          port_ok_d[cmd_idx] = 1'b0;
          guest_open_d[cmd_idx] = 1'b0;
          console_d[cmd_idx] = 1'b0;
        end
        cpc_pkg::EV_CONSOLE: console_d[cmd_idx] = 1'b1; // R7
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_i_n) begin
    if (!rst_i_n) begin
      for (int i = 0; i < 7; i++) rxb_q[i] <= 8'h0;
      rcnt_q <= 4'h0;
      txq_ready_q <= 1'b0;
      drv_ready_q <= 1'b0;
      port_exists_q <= cpc_pkg::EXISTS_RST;
      port_ok_q <= '0;
      guest_open_q <= '0;
      console_q <= '0;
    end else begin
      rxb_q <= rxb_d;
      rcnt_q <= rcnt_d;
      txq_ready_q <= 1'b1;
      drv_ready_q <= drv_ready_d;
      port_exists_q <= port_exists_d;
      port_ok_q <= port_ok_d;
      guest_open_q <= guest_open_d;
      console_q <= console_d;
    end
  end

  logic [31:0] limit_q;
  always_ff @(posedge clk_sys or negedge rst_i_n) begin
    if (!rst_i_n) limit_q <= 32'h0;
    else          limit_q <= multiport_en ? cpc_pkg::PORT_COUNT_LIMIT : 32'h0; // R18
  end

  assign cmd_ready = cmd_ready_q;
  assign cmd_reject = cmd_reject_q;
  assign name_ready = name_ready_q;
  assign rxq_valid = rxq_valid_q;
  assign rxq_data = rxq_data_q;
  assign rxq_last = rxq_last_q;
  assign txq_ready = txq_ready_q;
  assign port_count_limit = limit_q;
  assign drv_ready = drv_ready_q;
  assign port_exists = port_exists_q;
  assign port_ok = port_ok_q;
  assign guest_open = guest_open_q;
  assign console_port = console_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic hdr_push;
  assign hdr_push = state_q == cpc_pkg::CPC_HDR && slot_free;

  a_create_range: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R11
    cmd_take && cmd_event == cpc_pkg::EV_PORT_ADD && !port_in |=> cmd_reject_q)
    else $error("creation above port limit not refused");
  a_create_dup: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R11
    cmd_take && cmd_event == cpc_pkg::EV_PORT_ADD && port_ex |=> cmd_reject_q)
    else $error("creation of existing port not refused");
  a_remove_known: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R12
    cmd_take && cmd_event == cpc_pkg::EV_PORT_REMOVE && !port_ex
    |=> cmd_reject_q && state_q == cpc_pkg::CPC_IDLE)
    else $error("removal of unknown port not refused");
  a_port0_kept: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R20
    port_exists_q[0])
    else $error("port 0 disappeared");
  a_no_multiport: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R2
    cmd_take && !multiport_en |=> cmd_reject_q ##1 state_q == cpc_pkg::CPC_IDLE)
    else $error("command sent without multiport");
  a_event_low_le: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R1
    hdr_push && cnt_q == cpc_pkg::IDX_EVENT && !be_q |=> rxq_data_q == ev_q[7:0])
    else $error("event low byte not first in little-endian");
  a_event_hi_be: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R15
    hdr_push && cnt_q == cpc_pkg::IDX_EVENT && be_q |=> rxq_data_q == ev_q[15:8])
    else $error("event high byte not first in native order");
  a_resize_tail: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R8
    hdr_push && cnt_q == cpc_pkg::IDX_HDR_LAST && ev_q == cpc_pkg::EV_RESIZE
    |=> !rxq_last_q && state_q == cpc_pkg::CPC_EXT)
    else $error("resize header closed before sizes");
  a_name_follows: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R10
    hdr_push && cnt_q == cpc_pkg::IDX_HDR_LAST && ev_q == cpc_pkg::EV_PORT_NAME
    |=> !rxq_last_q && state_q == cpc_pkg::CPC_NAME)
    else $error("name header closed before name bytes");
  a_unknown_drop: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R21
    apply && r_ev > cpc_pkg::EV_PORT_NAME && !(cmd_take && cmd_ok)
    |=> $stable(port_ok_q) && $stable(guest_open_q) && $stable(drv_ready_q))
    else $error("unknown driver event changed state");
  a_add_marks: assert property (@(posedge clk_sys) disable iff (!rst_i_n) // R4
    cmd_take && cmd_ok && cmd_event == cpc_pkg::EV_PORT_ADD
    |=> port_exists_q[$past(cmd_idx)])
    else $error("created port not marked present");
endmodule

// ### tb/cpc_guest_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// guest driver seen from the control queues
// ------------------------------------------
module cpc_guest_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       legacy_be,
  input  wire logic       rxq_valid,
  output logic            rxq_ready,
  input  wire logic [7:0] rxq_data,
  input  wire logic       rxq_last,
  output logic            txq_valid,
  input  wire logic       txq_ready,
  output logic [7:0]      txq_data,
  output logic            txq_last
);
  logic        stall = 1'b0;
  logic [7:0]  rx_buf [0:15];
  int          rx_len = 0;
  int          rx_cnt = 0;
  int          idx = 0;
  logic [63:0] tx_q [$];

  function automatic logic [31:0] fld(int off, int n);
    logic [31:0] r;
    r = '0;
    for (int j = 0; j < n; j++) begin
      r[8*(legacy_be ? n-1-j : j) +: 8] = rx_buf[off+j];
    end
    return r;
  endfunction

  function automatic logic [7:0] enc(logic [63:0] m, int i);
    int          k;
    int          n;
    logic [31:0] f;
    f = (i < 4) ? m[63:32] : (i < 6) ? {16'h0000, m[31:16]} : {16'h0000, m[15:0]};
    k = (i < 4) ? i : (i < 6) ? i - 4 : i - 6;
    n = (i < 4) ? 4 : 2;
    return f[8*(legacy_be ? n-1-k : k) +: 8];
  endfunction

  // a slow guest is ready on every other cycle only
  always @(negedge clk_sys) rxq_ready <= rst_n && (!stall || !rxq_ready);

  always @(posedge clk_sys) begin
    if (rxq_valid && rxq_ready) begin
      rx_buf[idx] = rxq_data;
      idx = idx + 1;
      if (rxq_last) begin
        rx_len = idx;
        idx = 0;
        rx_cnt = rx_cnt + 1;
        if (fld(4, 2) == 32'h1) tx_q.push_back({fld(0, 4), 16'h0003, 16'h0001});
        if (fld(4, 2) == 32'h4) tx_q.push_back({fld(0, 4), 16'h0006, 16'h0001});
      end
    end
  end

  initial begin
    txq_valid = 1'b0;
    txq_data = 8'h00;
    txq_last = 1'b0;
    tx_q.push_back(64'h0000_0000_0000_0001);
    forever begin
      @(negedge clk_sys);
      if (rst_n && tx_q.size() > 0) begin
        // a whole message in one unbroken run, as one descriptor carries it
        for (int i = 0; i < 8; i++) begin
          txq_valid = 1'b1;
          txq_data = enc(tx_q[0], i);
          txq_last = (i == 7);
          do @(posedge clk_sys); while (!txq_ready);
          @(negedge clk_sys);
        end
        void'(tx_q.pop_front());
        txq_valid = 1'b0;
        txq_last = 1'b0;
      end
      txq_data = ~txq_data;
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n, multiport_en, legacy_be, cmd_valid, cmd_ready, cmd_reject;
  logic [15:0] cmd_event, cmd_value, cmd_cols, cmd_rows;
  logic [31:0] cmd_port, port_count_limit;
  logic name_valid, name_ready, name_last, rxq_valid, rxq_ready, rxq_last;
  logic txq_valid, txq_ready, txq_last, drv_ready;
  logic [7:0] name_data, rxq_data, txq_data;
  logic [cpc_pkg::NPORT-1:0] port_exists, port_ok, guest_open, console_port;
  int miscompares = 0;
  int samples_checked = 0;
  int seen = 0;

  always #10 clk_sys = ~clk_sys;

  cpc_console_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .multiport_en(multiport_en),
    .legacy_be(legacy_be), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_event(cmd_event), .cmd_port(cmd_port), .cmd_value(cmd_value), .cmd_cols(cmd_cols),
    .cmd_rows(cmd_rows), .cmd_reject(cmd_reject), .name_valid(name_valid),
    .name_ready(name_ready), .name_data(name_data), .name_last(name_last),
    .rxq_valid(rxq_valid), .rxq_ready(rxq_ready), .rxq_data(rxq_data), .rxq_last(rxq_last),
    .txq_valid(txq_valid), .txq_ready(txq_ready), .txq_data(txq_data), .txq_last(txq_last),
    .port_count_limit(port_count_limit), .drv_ready(drv_ready), .port_exists(port_exists),
    .port_ok(port_ok), .guest_open(guest_open), .console_port(console_port));

  cpc_guest_model drv (.clk_sys(clk_sys), .rst_n(rst_n), .legacy_be(legacy_be),
    .rxq_valid(rxq_valid), .rxq_ready(rxq_ready), .rxq_data(rxq_data), .rxq_last(rxq_last),
    .txq_valid(txq_valid), .txq_ready(txq_ready), .txq_data(txq_data), .txq_last(txq_last));

  // ----------------
  // common helpers
  // ----------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic fail(string msg);
    miscompares++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic chk(logic ok, string msg);
    samples_checked++;
    if (ok !== 1'b1) fail(msg);
  endtask

  task automatic tick(inout int n, input string msg);
    @(negedge clk_sys);
    n++;
    if (n > 300) begin
      fail(msg);
      summarize();
    end
  endtask

  task automatic send_cmd(logic [15:0] ev, logic [31:0] port, logic [15:0] val, logic rej);
    int n;
    n = 0;
    seen = drv.rx_cnt;
    while (cmd_ready !== 1'b1) tick(n, "command port stuck");
    cmd_valid = 1'b1;
    cmd_event = ev;
    cmd_port = port;
    cmd_value = val;
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    chk(cmd_reject === rej, "refusal flag wrong");
    // one idle cycle keeps back-to-back commands from reusing this time step
    @(negedge clk_sys);
  endtask

  task automatic send_name(logic [7:0] b, logic l);
    int n;
    n = 0;
    while (name_ready !== 1'b1) tick(n, "name stream stuck");
    name_valid = 1'b1;
    name_data = b;
    name_last = l;
    @(posedge clk_sys);
    @(negedge clk_sys);
    name_valid = 1'b0;
    name_data = ~b;
  endtask

  // expected bytes stand left-aligned, first byte on the wire leftmost
  task automatic wait_frame(logic [95:0] exp, int len);
    int n;
    n = 0;
    while (drv.rx_cnt == seen) tick(n, "no frame on receive queue");
    chk(drv.rx_len == len, "frame length wrong");
    for (int i = 0; i < len; i++) chk(drv.rx_buf[i] === exp[95-8*i -: 8], "frame byte wrong");
  endtask

  task automatic settle();
    int n;
    n = 0;
    while (drv.tx_q.size() != 0 || txq_valid !== 1'b0) tick(n, "driver queue stuck");
    repeat (2) @(negedge clk_sys);
  endtask

  // -----------
  // scenarios
  // -----------
  task automatic t_reset();
    settle();
    chk(port_exists === 8'h01, "only port 0 after reset");
    chk(port_count_limit === cpc_pkg::PORT_COUNT_LIMIT, "port limit");
    chk(drv_ready === 1'b1, "driver readiness not seen");
  endtask

  task automatic t_add();
    send_cmd(16'h0001, 32'h3, 16'h0000, 1'b0);
    wait_frame(96'h03000000_0100_0000_00000000, 8);
    settle();
    chk(port_exists === 8'h09, "port 3 not created");
    chk(port_ok[3] === 1'b1, "port ready reply lost");
  endtask

  task automatic t_refuse();
    send_cmd(16'h0001, 32'h3, 16'h0000, 1'b1);
    send_cmd(16'h0001, 32'h8, 16'h0000, 1'b1);
    send_cmd(16'h0002, 32'h5, 16'h0000, 1'b1);
    send_cmd(16'h0008, 32'h3, 16'h0000, 1'b1);
    chk(port_exists === 8'h09, "refusal changed ports");
  endtask

  task automatic t_console();
    send_cmd(16'h0004, 32'h3, 16'h0000, 1'b0);
    wait_frame(96'h03000000_0400_0000_00000000, 8);
    send_cmd(16'h0004, 32'h0, 16'h0000, 1'b0);
    wait_frame(96'h00000000_0400_0000_00000000, 8);
    settle();
    chk(console_port === 8'h09, "two consoles expected");
    chk(guest_open === 8'h09, "open reply lost");
  endtask

  task automatic t_resize_name();
    cmd_cols = 16'h0050;
    cmd_rows = 16'h0019;
    send_cmd(16'h0005, 32'h3, 16'h0000, 1'b0);
    wait_frame(96'h03000000_0500_0000_5000_1900, 12);
    send_cmd(16'h0007, 32'h3, 16'h0000, 1'b0);
    send_name(8'h61, 1'b0);
    send_name(8'h62, 1'b1);
    wait_frame(96'h03000000_0700_0000_6162_0000, 10);
  endtask

  task automatic t_open_remove();
    send_cmd(16'h0006, 32'h3, 16'h0001, 1'b0);
    wait_frame(96'h03000000_0600_0100_00000000, 8);
    send_cmd(16'h0002, 32'h3, 16'h0000, 1'b0);
    wait_frame(96'h03000000_0200_0000_00000000, 8);
    chk(port_exists === 8'h01, "port 3 not removed");
    chk(console_port === 8'h01, "removed port still console");
  endtask

  task automatic t_legacy();
    legacy_be = 1'b1;
    drv.stall = 1'b1;
    send_cmd(16'h0001, 32'h2, 16'h0000, 1'b0);
    wait_frame(96'h00000002_0001_0000_00000000, 8);
    settle();
    chk(port_ok[2] === 1'b1, "big-endian reply lost");
    drv.stall = 1'b0;
    legacy_be = 1'b0;
  endtask

  task automatic t_unknown();
    drv.tx_q.push_back({32'h0, 16'h0009, 16'h0000});
    settle();
    chk(guest_open[0] === 1'b1, "unknown event changed state");
    drv.tx_q.push_back({32'h0, 16'h0006, 16'h0000});
    settle();
    chk(guest_open[0] === 1'b0, "guest close lost");
  endtask

  task automatic t_nomulti();
    multiport_en = 1'b0;
    send_cmd(16'h0001, 32'h4, 16'h0000, 1'b1);
    chk(port_count_limit === 32'h0, "limit shown without multiport");
    multiport_en = 1'b1;
  endtask

  initial begin
    rst_n = 1'b0;
    multiport_en = 1'b1;
    legacy_be = 1'b0;
    cmd_valid = 1'b0;
    cmd_event = 16'h0000;
    cmd_port = 32'h0;
    cmd_value = 16'h0000;
    cmd_cols = 16'h0000;
    cmd_rows = 16'h0000;
    name_valid = 1'b0;
    name_data = 8'h00;
    name_last = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_add();
    t_refuse();
    t_console();
    t_resize_name();
    t_open_remove();
    t_legacy();
    t_unknown();
    t_nomulti();
    summarize();
  end
endmodule
